/* tb/trrp_core_tb_top.sv */
`timescale 1ns/1ps
module trrp_core_tb_top;
  logic clk, nrst, cmd_valid, data_strobe, ctrl_wr, ctrl_rd, page_reserved;
  logic [15:0] cmd_word, wr_data, rd_data, ctrl_wr_data, status_in;
  trrp_pkg::trrp_result_t result_in;
  trrp_pkg::trrp_ptr_t ctrl_ptr;
  int errors, compares;
  trrp_core u_dut (.clk(clk), .nrst(nrst), .result_in(result_in), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .data_strobe(data_strobe), .wr_data(wr_data), .rd_data(rd_data),
    .ctrl_wr(ctrl_wr), .ctrl_rd(ctrl_rd), .ctrl_ptr(ctrl_ptr), .ctrl_wr_data(ctrl_wr_data),
    .ctrl_status(status_in), .page_reserved(page_reserved));
  trrp_host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .data_strobe(data_strobe), .wr_data(wr_data));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [16:0] seen, exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [15:0] exp);
    @(posedge clk);
    #1 check({1'b0, rd_data}, {1'b0, exp}, "rd_data");
  endtask
  function automatic logic [15:0] val(input int i, input bit full);
    // Upper nibble zero, MSB of the value set
    return (full && i != 4 && i != 8) ? {4'h0, 12'hc30 ^ 12'(i)} : 16'h0000;
  endfunction
  // Page 0 indexes 0 to 0x0a, reserved 4 and 8 read zero
  task automatic burst(input bit full);
    u_host.send(16'h8000);
    for (int i = 0; i < 11; i++)
    begin
      if (i > 0)
        u_host.step(16'h0000);
      rd(val(i, full));
    end
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    errors++;
    complete_run();
  end
  initial
  begin
    errors = 0;
    compares = 0;
    nrst = 1'b0;
    result_in = '0;
    status_in = 16'h5a3c;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    burst(1'b0);
    for (int i = 0; i < 11; i++)
    begin
      @(posedge clk) result_in <= {(i != 4 && i != 8), 6'(i), 12'(val(i, 1'b1))};
      @(posedge clk) result_in.valid <= 1'b0;
    end
    burst(1'b1);
    u_host.send(16'h0000);
    u_host.step(16'h0fff);
    burst(1'b1);
    @(posedge clk) nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    burst(1'b0);
    u_host.send(16'h83e0);
    rd(16'h0000);
    u_host.step(16'h0000);
    rd(16'hffff);
    u_host.send(16'h9800);
    rd(16'hffff);
    check(17'(page_reserved), 17'h1, "page_reserved");
    u_host.send(16'h8800);
    rd(16'h5a3c);
    fork
      u_host.step(16'h0000);
      begin
        @(posedge clk);
        #1 check({ctrl_wr, ctrl_rd, 15'h0}, 17'h08000, "ctrl_rd");
      end
    join
    u_host.send(16'h1000);
    fork
      u_host.step(16'h0f0f);
      begin
        @(posedge clk);
        #1 check({ctrl_wr, ctrl_wr_data}, 17'h10f0f, "ctrl_wr");
      end
    join
    #1 check(17'(ctrl_ptr), 17'h00012, "ctrl_ptr");
    complete_run();
  end
endmodule

/* tb/trrp_host_model.sv */
`timescale 1ns/1ps
module trrp_host_model (
  // Clock
  input wire logic clk,
  // Host access
  output logic cmd_valid,
  output logic [15:0] cmd_word,
  output logic data_strobe,
  output logic [15:0] wr_data
);
  initial {cmd_valid, cmd_word, data_strobe, wr_data} = '0;
  // Command word, then one strobe per word
  task automatic send(input logic [15:0] w);
    @(posedge clk) cmd_valid <= 1'b1;
    cmd_word <= w;
    @(posedge clk) cmd_valid <= 1'b0;
    cmd_word <= ~w;
  endtask
  // Released data shows inverse, not a stale copy
  task automatic step(input logic [15:0] d);
    @(posedge clk) data_strobe <= 1'b1;
    wr_data <= d;
    @(posedge clk) data_strobe <= 1'b0;
    wr_data <= ~d;
  endtask
endmodule

/* verilog/trrp_core.sv */
`timescale 1ns/1ps
module trrp_core #(
  parameter int unsigned NUM_RESULTS = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Conversion result input
  input wire trrp_pkg::trrp_result_t result_in,
  // Decoded host access, from the serial front end
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic data_strobe,
  input wire logic [15:0] wr_data,
  // Read data and control page hand-off
  output logic [15:0] rd_data,
  output logic ctrl_wr,
  output logic ctrl_rd,
  output trrp_pkg::trrp_ptr_t ctrl_ptr,
  output logic [15:0] ctrl_wr_data,
  input wire logic [15:0] ctrl_status,
  output logic page_reserved
);

  localparam logic [5:0] OFFS [NUM_RESULTS] = '{
    trrp_pkg::HORIZONTAL_POSITION_RESULT, trrp_pkg::VERTICAL_POSITION_RESULT,
    trrp_pkg::FIRST_PRESSURE_RESULT, trrp_pkg::SECOND_PRESSURE_RESULT,
    trrp_pkg::FIRST_BATTERY_RESULT, trrp_pkg::SECOND_BATTERY_RESULT,
    trrp_pkg::EXTRA_INPUT_RESULT, trrp_pkg::FIRST_THERMAL_RESULT,
    trrp_pkg::SECOND_THERMAL_RESULT};

  logic [15:0] res_q [NUM_RESULTS];
  logic is_read_q;
  logic past_end_q;
  trrp_pkg::trrp_ptr_t ptr_q;
  logic [15:0] sel_word;
  logic page_ok;
  logic [3:0] cmd_page;

  assign cmd_page = cmd_word[trrp_pkg::CMD_PAGE_LSB +: trrp_pkg::PAGE_W];

  // Result registers; only the conversion path writes them
  genvar g;
  generate
    for (g = 0; g < NUM_RESULTS; g++)
    begin : g_res
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          res_q[g] <= trrp_pkg::RESULT_RESET;
        else if (result_in.valid && result_in.idx == OFFS[g])
          res_q[g] <= {4'h0, result_in.value};
      end
    end
  endgenerate

  // Command latch and auto-increment pointer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ptr_q <= '0;
      is_read_q <= 1'b0;
      past_end_q <= 1'b0;
    end
    else if (cmd_valid)
    begin
      ptr_q.page <= cmd_page;
      ptr_q.idx <= cmd_word[trrp_pkg::CMD_IDX_LSB +: trrp_pkg::IDX_W];
      is_read_q <= cmd_word[trrp_pkg::CMD_DIR_BIT];
      past_end_q <= 1'b0;
    end
    else if (data_strobe)
    begin
      // Pointer stops at page end rather than wrapping
      if (ptr_q.idx == trrp_pkg::PAGE_LAST_IDX)
        past_end_q <= 1'b1;
      else
        ptr_q.idx <= ptr_q.idx + 6'h01;
    end
  end

  assign page_ok = ptr_q.page == trrp_pkg::PAGE_RESULT ||
    ptr_q.page == trrp_pkg::PAGE_TOUCH || ptr_q.page == trrp_pkg::PAGE_AUDIO;
  assign page_reserved = !page_ok;

  always_comb
  begin
    sel_word = trrp_pkg::RESERVED_READ;
    for (int i = 0; i < NUM_RESULTS; i++)
      if (ptr_q.idx == OFFS[i])
        sel_word = res_q[i];
  end

  // Read word registered so it is stable for the shifter
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rd_data <= trrp_pkg::RESULT_RESET;
    else if (past_end_q || !page_ok)
      rd_data <= trrp_pkg::PAST_END_READ;
    else if (ptr_q.page == trrp_pkg::PAGE_RESULT)
      rd_data <= sel_word;
    else
      rd_data <= ctrl_status;
  end

  // Control pages live elsewhere; writes to page 0 are dropped
  assign ctrl_wr = data_strobe && !is_read_q && !past_end_q && page_ok &&
    ptr_q.page != trrp_pkg::PAGE_RESULT;
  assign ctrl_rd = data_strobe && is_read_q && !past_end_q && page_ok &&
    ptr_q.page != trrp_pkg::PAGE_RESULT;
  assign ctrl_ptr = ptr_q;
  assign ctrl_wr_data = wr_data;

  a_upper_zero: assert property (@(posedge clk) disable iff (!nrst)
    (ptr_q.page == trrp_pkg::PAGE_RESULT && !past_end_q && page_ok) |=>
    rd_data[15:12] == 4'h0 || $past(cmd_valid) || $past(data_strobe))
    else $error("result upper bits not zero");
  a_ro_hold: assert property (@(posedge clk) disable iff (!nrst)
    (!result_in.valid) |=> res_q[5] == $past(res_q[5]))
    else $error("result changed without conversion");
  a_res_store: assert property (@(posedge clk) disable iff (!nrst)
    (result_in.valid && result_in.idx == trrp_pkg::SECOND_THERMAL_RESULT) |=>
    res_q[8] == {4'h0, $past(result_in.value)})
    else $error("thermal result not stored");
  a_past_end: assert property (@(posedge clk) disable iff (!nrst)
    (past_end_q && !cmd_valid) |=> rd_data == trrp_pkg::PAST_END_READ)
    else $error("past end read not all ones");
  a_incr: assert property (@(posedge clk) disable iff (!nrst)
    (data_strobe && !cmd_valid && ptr_q.idx != trrp_pkg::PAGE_LAST_IDX) |=>
    ptr_q.idx == $past(ptr_q.idx) + 6'h01)
    else $error("pointer did not advance");
  a_no_p0_wr: assert property (@(posedge clk) disable iff (!nrst)
    (ptr_q.page == trrp_pkg::PAGE_RESULT) |-> !ctrl_wr)
    else $error("page 0 write leaked");
  a_bad_page: assert property (@(posedge clk) disable iff (!nrst)
    (ptr_q.page > trrp_pkg::PAGE_AUDIO) |-> page_reserved && !ctrl_wr && !ctrl_rd)
    else $error("reserved page selected");
  a_rsv_zero: assert property (@(posedge clk) disable iff (!nrst)
    (ptr_q.page == trrp_pkg::PAGE_RESULT && ptr_q.idx == 6'h04 && !past_end_q
     && !cmd_valid) |=> rd_data == trrp_pkg::RESERVED_READ)
    else $error("reserved address not zero");
  a_ctrl_read: assert property (@(posedge clk) disable iff (!nrst)
    (ptr_q.page == trrp_pkg::PAGE_TOUCH && !past_end_q && !cmd_valid) |=>
    rd_data == $past(ctrl_status))
    else $error("control read not status");

  // Reset checks run without disable so they see the reset itself
  a_rst_results: assert property (
    @(posedge clk)
    !nrst
    |-> res_q[0] == trrp_pkg::RESULT_RESET && res_q[4] == trrp_pkg::RESULT_RESET)
    else $error("results not cleared in reset");

  a_rst_outputs: assert property (
    @(posedge clk)
    !nrst
    |-> rd_data == trrp_pkg::RESULT_RESET && !page_reserved && ctrl_ptr == '0)
    else $error("outputs not idle in reset");

  a_res_first: assert property (
    @(posedge clk) disable iff (!nrst)
    result_in.valid && result_in.idx == trrp_pkg::HORIZONTAL_POSITION_RESULT
    |=> res_q[0] == {4'h0, $past(result_in.value)})
    else $error("position result not stored");

  a_res_battery: assert property (
    @(posedge clk) disable iff (!nrst)
    result_in.valid && result_in.idx == trrp_pkg::SECOND_BATTERY_RESULT
    |=> res_q[5] == {4'h0, $past(result_in.value)})
    else $error("battery result not stored");

  a_res_rsv_idx: assert property (
    @(posedge clk) disable iff (!nrst)
    result_in.valid && result_in.idx == 6'h04
    |=> res_q[3] == $past(res_q[3]) && res_q[4] == $past(res_q[4]))
    else $error("reserved index touched a result");

  a_res_nibble: assert property (
    @(posedge clk) disable iff (!nrst)
    nrst
    |-> res_q[0][15:12] == 4'h0 && res_q[8][15:12] == 4'h0)
    else $error("result upper nibble set");

  a_p0_read: assert property (
    @(posedge clk) disable iff (!nrst)
    ptr_q.page == trrp_pkg::PAGE_RESULT && !past_end_q && ptr_q.idx == 6'h05
    |=> rd_data == $past(res_q[4]))
    else $error("battery read wrong");

  a_p0_pressure: assert property (
    @(posedge clk) disable iff (!nrst)
    ptr_q.page == trrp_pkg::PAGE_RESULT && !past_end_q && ptr_q.idx == 6'h02
    |=> rd_data == $past(res_q[2]))
    else $error("pressure read wrong");

  a_cmd_latch: assert property (
    @(posedge clk) disable iff (!nrst)
    cmd_valid
    |=> ptr_q.page == $past(cmd_page) && ptr_q.idx == $past(cmd_word[10:5]))
    else $error("command not latched");

  a_cmd_dir: assert property (
    @(posedge clk) disable iff (!nrst)
    cmd_valid
    |=> is_read_q == $past(cmd_word[15]))
    else $error("direction not latched");

  a_cmd_clear_end: assert property (
    @(posedge clk) disable iff (!nrst)
    cmd_valid
    |=> !past_end_q)
    else $error("new command kept past end");

  a_end_stop: assert property (
    @(posedge clk) disable iff (!nrst)
    data_strobe && !cmd_valid && ptr_q.idx == trrp_pkg::PAGE_LAST_IDX
    |=> past_end_q && ptr_q.idx == trrp_pkg::PAGE_LAST_IDX)
    else $error("pointer wrapped at page end");

  a_end_sticky: assert property (
    @(posedge clk) disable iff (!nrst)
    past_end_q && !cmd_valid
    |=> past_end_q)
    else $error("past end dropped");

  a_idle_hold: assert property (
    @(posedge clk) disable iff (!nrst)
    !cmd_valid && !data_strobe
    |=> $stable(ptr_q) && $stable(past_end_q))
    else $error("pointer moved while idle");

  a_rsv_page_rd: assert property (
    @(posedge clk) disable iff (!nrst)
    page_reserved
    |=> rd_data == trrp_pkg::PAST_END_READ)
    else $error("reserved page read not all ones");

  a_page_decode: assert property (
    @(posedge clk) disable iff (!nrst)
    !page_reserved
    |-> ptr_q.page <= trrp_pkg::PAGE_AUDIO)
    else $error("reserved page accepted");

  a_wr_dir: assert property (
    @(posedge clk) disable iff (!nrst)
    ctrl_wr
    |-> !is_read_q && data_strobe)
    else $error("control write without write strobe");

  a_rd_dir: assert property (
    @(posedge clk) disable iff (!nrst)
    ctrl_rd
    |-> is_read_q && data_strobe)
    else $error("control read without read strobe");

  a_ctrl_excl: assert property (
    @(posedge clk) disable iff (!nrst)
    nrst
    |-> !(ctrl_wr && ctrl_rd))
    else $error("control read and write together");

  a_ctrl_end: assert property (
    @(posedge clk) disable iff (!nrst)
    past_end_q
    |-> !ctrl_wr && !ctrl_rd)
    else $error("control access past page end");

  a_p0_no_rd: assert property (
    @(posedge clk) disable iff (!nrst)
    ptr_q.page == trrp_pkg::PAGE_RESULT
    |-> !ctrl_rd)
    else $error("page 0 read leaked");

  a_ctrl_page: assert property (
    @(posedge clk) disable iff (!nrst)
    ctrl_wr || ctrl_rd
    |-> ptr_q.page == trrp_pkg::PAGE_TOUCH || ptr_q.page == trrp_pkg::PAGE_AUDIO)
    else $error("control access on wrong page");

  a_audio_read: assert property (
    @(posedge clk) disable iff (!nrst)
    ptr_q.page == trrp_pkg::PAGE_AUDIO && !past_end_q
    |=> rd_data == $past(ctrl_status))
    else $error("audio page read not status");

  a_wr_pass: assert property (
    @(posedge clk) disable iff (!nrst)
    ctrl_wr
    |-> ctrl_wr_data == wr_data)
    else $error("control write data lost");
endmodule

/* verilog/trrp_pkg.sv */
package trrp_pkg;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned RES_W = 12;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned PAGE_W = 4;
  localparam int unsigned KIND_W = 4;
  // Command word fields
  localparam int unsigned CMD_DIR_BIT = 15;
  localparam int unsigned CMD_PAGE_LSB = 11;
  localparam int unsigned CMD_IDX_LSB = 5;
  // Page codes
  localparam logic [3:0] PAGE_RESULT = 4'h0;
  localparam logic [3:0] PAGE_TOUCH = 4'h1;
  localparam logic [3:0] PAGE_AUDIO = 4'h2;
  // Result register offsets on page 0
  localparam logic [5:0] HORIZONTAL_POSITION_RESULT = 6'h00;
  localparam logic [5:0] VERTICAL_POSITION_RESULT = 6'h01;
  localparam logic [5:0] FIRST_PRESSURE_RESULT = 6'h02;
  localparam logic [5:0] SECOND_PRESSURE_RESULT = 6'h03;
  localparam logic [5:0] FIRST_BATTERY_RESULT = 6'h05;
  localparam logic [5:0] SECOND_BATTERY_RESULT = 6'h06;
  localparam logic [5:0] EXTRA_INPUT_RESULT = 6'h07;
  localparam logic [5:0] FIRST_THERMAL_RESULT = 6'h09;
  localparam logic [5:0] SECOND_THERMAL_RESULT = 6'h0a;
  localparam logic [5:0] PAGE_LAST_IDX = 6'h1f;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] RESERVED_READ = 16'h0000;
  localparam logic [15:0] PAST_END_READ = 16'hffff;
  typedef struct packed {
    logic valid;
    logic [5:0] idx;
    logic [11:0] value;
  } trrp_result_t;
  typedef struct packed {
    logic [5:0] idx;
    logic [3:0] page;
  } trrp_ptr_t;
endpackage
